/* src/dgio_edge.sv */
`timescale 1ns/1ps
module dgio_edge (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	input  wire logic rise_in,
	input  wire logic fall_in,
	input  wire logic ack_in,
	output logic      flag_out
);
	logic rise_q, fall_q, flag_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else if (ce_in) begin
			rise_q <= rise_in;
			fall_q <= fall_in;
		end
	end

	// A new edge in the acknowledge cycle keeps the flag set.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			flag_q <= 1'b0;
		end else if (ce_in) begin
			if ((rise_in && !rise_q) || (!fall_in && fall_q)) begin
				flag_q <= 1'b1;
			end else if (ack_in) begin
				flag_q <= 1'b0;
			end
		end
	end

	assign flag_out = flag_q;
endmodule : dgio_edge

/* src/dgio_pkg.sv */
package dgio_pkg;
	// ============================================================
	// Special function register addresses.
	localparam logic [7:0] PORT0_DATA_ADDR      = 8'h80;
	localparam logic [7:0] PORT1_DATA_ADDR      = 8'h90;
	localparam logic [7:0] PORT1_DIRECTION_ADDR = 8'h91;
	localparam logic [7:0] PORT2_DATA_ADDR      = 8'hA0;
	localparam logic [7:0] PORT2_DIRECTION_ADDR = 8'hA1;
	localparam logic [7:0] PORT0_DIRECTION_ADDR = 8'hA2;
	// ============================================================
	// Configuration RAM addresses.
	localparam logic [15:0] SPECIAL_CTRL_ADDR   = 16'h2008;
	localparam logic [15:0] SELECT_BASE_ADDR    = 16'h2009;
	localparam logic [15:0] SELECT_LAST_ADDR    = 16'h200E;
	localparam logic [15:0] LCD_COUNT_ADDR      = 16'h2020;
	// ============================================================
	// Field positions and widths.
	localparam int STROBE_ENABLE_BIT  = 2;
	localparam int FAULT_ENABLE_BIT   = 3;
	localparam int EEPROM_ENABLE_BIT  = 4;
	localparam int LCD_COUNT_WIDTH    = 5;
	localparam int SELECT_WIDTH       = 3;
	localparam int SELECT_HI_LSB      = 4;
	localparam int STROBE_PIN         = 6;
	localparam int FAULT_PIN          = 7;
	localparam int EEPROM_CLK_PIN     = 4;
	localparam int EEPROM_DATA_PIN    = 5;
	// ============================================================
	// Reset values.
	localparam logic [7:0] DIRECTION_RESET   = 8'h00;
	localparam logic [7:0] DATA_RESET        = 8'hFF;
	localparam logic [7:0] CONFIG_RESET      = 8'h00;
	// ============================================================
	// Resource selector codes.
	typedef enum logic [2:0] {
		DGIO_SEL_NONE     = 3'h0,
		DGIO_SEL_RESERVED = 3'h1,
		DGIO_SEL_TIMER0   = 3'h2,
		DGIO_SEL_TIMER1   = 3'h3,
		DGIO_SEL_HI_RISE  = 3'h4,
		DGIO_SEL_LO_RISE  = 3'h5,
		DGIO_SEL_HI_FALL  = 3'h6,
		DGIO_SEL_LO_FALL  = 3'h7
	} dgio_sel_t;
endpackage : dgio_pkg

/* src/dgio_route.sv */
`timescale 1ns/1ps
module dgio_route
	import dgio_pkg::*;
#(
	parameter int ROUTED_PINS = 12
) (
	input  wire logic [ROUTED_PINS-1:0]              level_in,
	input  wire logic [ROUTED_PINS*SELECT_WIDTH-1:0] select_in,
	output logic                                     timer0_out,
	output logic                                     timer1_out,
	output logic                                     hi_rise_out,
	output logic                                     lo_rise_out,
	output logic                                     hi_fall_out,
	output logic                                     lo_fall_out
);
	logic [ROUTED_PINS-1:0] t0_v, t1_v, hr_v, lr_v, hf_v, lf_v;

	// Each pin raises its lane only for its own code; lanes are ORed per resource.
	for (genvar i = 0; i < ROUTED_PINS; i++) begin : g_pin
		logic [SELECT_WIDTH-1:0] s;
		assign s = select_in[i*SELECT_WIDTH +: SELECT_WIDTH];
		assign t0_v[i] = level_in[i] && (s == DGIO_SEL_TIMER0);
		assign t1_v[i] = level_in[i] && (s == DGIO_SEL_TIMER1);
		assign hr_v[i] = level_in[i] && (s == DGIO_SEL_HI_RISE);
		assign lr_v[i] = level_in[i] && (s == DGIO_SEL_LO_RISE);
		assign hf_v[i] = level_in[i] && (s == DGIO_SEL_HI_FALL);
		assign lf_v[i] = level_in[i] && (s == DGIO_SEL_LO_FALL);
	end

	assign timer0_out  = |t0_v;
	assign timer1_out  = |t1_v;
	assign hi_rise_out = |hr_v;
	assign lo_rise_out = |lr_v;
	assign hi_fall_out = |hf_v;
	assign lo_fall_out = |lf_v;
endmodule : dgio_route

/* src/dgio_top.sv */
`timescale 1ns/1ps
module dgio_top
	import dgio_pkg::*;
#(
	parameter int PIN_COUNT    = 22,
	parameter int SHARED_PINS  = 18,
	parameter int ROUTED_PINS  = 12
) (
	input  wire logic                  MCLK_IN,
	input  wire logic                  RESET_N_IN,
	input  wire logic                  CLK_EN_IN,
	// Special function register port.
	input  wire logic [7:0]            SFR_ADDR_IN,
	input  wire logic [7:0]            SFR_WDATA_IN,
	input  wire logic                  SFR_WR_IN,
	input  wire logic                  SFR_RD_IN,
	output logic [7:0]                 SFR_RDATA_OUT,
	// Configuration RAM port.
	input  wire logic [15:0]           CFG_ADDR_IN,
	input  wire logic [7:0]            CFG_WDATA_IN,
	input  wire logic                  CFG_WR_IN,
	input  wire logic                  CFG_RD_IN,
	output logic [7:0]                 CFG_RDATA_OUT,
	// Pins.
	input  wire logic [PIN_COUNT-1:0]  PIN_IN,
	output logic [PIN_COUNT-1:0]       PIN_OUT,
	output logic [PIN_COUNT-1:0]       PIN_OE_N_OUT,
	output logic [SHARED_PINS-1:0]     LCD_SEGMENT_MODE_OUT,
	// Computation engine and EEPROM interface.
	input  wire logic                  CE_STROBE_IN,
	input  wire logic                  CE_FAULT_PULSE_IN,
	input  wire logic                  EE_CLK_IN,
	input  wire logic                  EE_DATA_IN,
	input  wire logic                  EE_DATA_OE_IN,
	output logic                       EE_DATA_OUT,
	// Timers and interrupt logic.
	output logic                       TIMER0_COUNT_INPUT_OUT,
	output logic                       TIMER1_COUNT_INPUT_OUT,
	input  wire logic                  HIGH_IRQ_ACK_IN,
	input  wire logic                  LOW_IRQ_ACK_IN,
	output logic                       HIGH_PRIORITY_PIN_IRQ_OUT,
	output logic                       LOW_PRIORITY_PIN_IRQ_OUT
);
	import dgio_pkg::*;

	localparam int SEL_REGS = 6;

	initial begin
		if (PIN_COUNT != 22 || SHARED_PINS > PIN_COUNT || ROUTED_PINS > 12 ||
				ROUTED_PINS < 8) begin
			$error("dgio_top: unsupported pin parameters");
		end
	end

	// ============================================================
	// Register state.
	logic [7:0]                      port0_data_q, port1_data_q, port2_data_q;
	logic [7:0]                      port0_direction_q, port1_direction_q, port2_direction_q;
	logic [7:0]                      special_ctrl_q;
	logic [LCD_COUNT_WIDTH-1:0]      lcd_segment_pin_count_q;
	logic [7:0]                      select_q [SEL_REGS];
	logic [7:0]                      sfr_rdata_q, cfg_rdata_q;

	logic [PIN_COUNT-1:0]            pin_direction_bit, out_latch, general_pin;
	logic [PIN_COUNT-1:0]            lcd_owned;
	logic [ROUTED_PINS*SELECT_WIDTH-1:0] pin_resource_select;
	logic                            strobe_pulse_enable, fault_pulse_enable;
	logic                            eeprom_pins_enable;

	assign pin_direction_bit = {port2_direction_q[5:0], port1_direction_q, port0_direction_q};
	assign out_latch = {port2_data_q[5:0], port1_data_q, port0_data_q};
	assign strobe_pulse_enable = special_ctrl_q[STROBE_ENABLE_BIT];
	assign fault_pulse_enable  = special_ctrl_q[FAULT_ENABLE_BIT];
	assign eeprom_pins_enable  = special_ctrl_q[EEPROM_ENABLE_BIT];

	// ============================================================
	// SFR writes; direction resets to input.
	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			port0_direction_q <= DIRECTION_RESET;
			port1_direction_q <= DIRECTION_RESET;
			port2_direction_q <= DIRECTION_RESET;
		end else if (CLK_EN_IN && SFR_WR_IN) begin
			case (SFR_ADDR_IN)
				PORT0_DIRECTION_ADDR: port0_direction_q <= SFR_WDATA_IN;
				PORT1_DIRECTION_ADDR: port1_direction_q <= SFR_WDATA_IN;
				PORT2_DIRECTION_ADDR: port2_direction_q <= {2'b00, SFR_WDATA_IN[5:0]};
				default: ;
			endcase
		end
	end

	// Writes to a data register only touch the output latch.
	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			port0_data_q <= DATA_RESET;
			port1_data_q <= DATA_RESET;
			port2_data_q <= {2'b00, DATA_RESET[5:0]};
		end else if (CLK_EN_IN && SFR_WR_IN) begin
			case (SFR_ADDR_IN)
				PORT0_DATA_ADDR: port0_data_q <= SFR_WDATA_IN;
				PORT1_DATA_ADDR: port1_data_q <= SFR_WDATA_IN;
				PORT2_DATA_ADDR: port2_data_q <= {2'b00, SFR_WDATA_IN[5:0]};
				default: ;
			endcase
		end
	end

	// Data reads mix pin levels of inputs with latch values of outputs.
	logic [PIN_COUNT-1:0] read_view;
	assign read_view = (pin_direction_bit & out_latch) | (~pin_direction_bit & PIN_IN);

	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			sfr_rdata_q <= 8'h00;
		end else if (CLK_EN_IN && SFR_RD_IN) begin
			case (SFR_ADDR_IN)
				PORT0_DATA_ADDR:      sfr_rdata_q <= read_view[7:0];
				PORT1_DATA_ADDR:      sfr_rdata_q <= read_view[15:8];
				PORT2_DATA_ADDR:      sfr_rdata_q <= {2'b00, read_view[21:16]};
				PORT0_DIRECTION_ADDR: sfr_rdata_q <= port0_direction_q;
				PORT1_DIRECTION_ADDR: sfr_rdata_q <= port1_direction_q;
				PORT2_DIRECTION_ADDR: sfr_rdata_q <= port2_direction_q;
				default:              sfr_rdata_q <= 8'h00;
			endcase
		end
	end
	assign SFR_RDATA_OUT = sfr_rdata_q;

	// ============================================================
	// Configuration RAM registers.
	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			special_ctrl_q <= CONFIG_RESET;
			lcd_segment_pin_count_q <= CONFIG_RESET[LCD_COUNT_WIDTH-1:0];
		end else if (CLK_EN_IN && CFG_WR_IN) begin
			if (CFG_ADDR_IN == SPECIAL_CTRL_ADDR) begin
				special_ctrl_q <= CFG_WDATA_IN;
			end
			if (CFG_ADDR_IN == LCD_COUNT_ADDR) begin
				lcd_segment_pin_count_q <= CFG_WDATA_IN[LCD_COUNT_WIDTH-1:0];
			end
		end
	end

	// Selector bytes each hold two 3-bit fields at bits 2:0 and 6:4.
	for (genvar r = 0; r < SEL_REGS; r++) begin : g_sel
		always_ff @(posedge MCLK_IN) begin
			if (!RESET_N_IN) begin
				select_q[r] <= CONFIG_RESET;
			end else if (CLK_EN_IN && CFG_WR_IN &&
					CFG_ADDR_IN == SELECT_BASE_ADDR + 16'(r)) begin
				select_q[r] <= CFG_WDATA_IN & 8'h77;
			end
		end
	end

	// Only the low pins get a selector; the rest stay unrouted.
	for (genvar p = 0; p < ROUTED_PINS; p++) begin : g_pack
		assign pin_resource_select[p*SELECT_WIDTH +: SELECT_WIDTH] =
			select_q[p/2][(p%2)*SELECT_HI_LSB +: SELECT_WIDTH];
	end

	logic cfg_sel_hit;
	assign cfg_sel_hit = CFG_ADDR_IN >= SELECT_BASE_ADDR && CFG_ADDR_IN <= SELECT_LAST_ADDR;

	always_ff @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			cfg_rdata_q <= 8'h00;
		end else if (CLK_EN_IN && CFG_RD_IN) begin
			if (CFG_ADDR_IN == SPECIAL_CTRL_ADDR) begin
				cfg_rdata_q <= special_ctrl_q;
			end else if (CFG_ADDR_IN == LCD_COUNT_ADDR) begin
				cfg_rdata_q <= {3'b000, lcd_segment_pin_count_q};
			end else if (cfg_sel_hit) begin
				cfg_rdata_q <= select_q[3'(CFG_ADDR_IN - SELECT_BASE_ADDR)];
			end else begin
				cfg_rdata_q <= 8'h00;
			end
		end
	end
	assign CFG_RDATA_OUT = cfg_rdata_q;

	// ============================================================
	// LCD sharing: count N hands the top N shared pins to the LCD.
	for (genvar k = 0; k < PIN_COUNT; k++) begin : g_lcd
		if (k >= PIN_COUNT - SHARED_PINS) begin : g_shared
			assign lcd_owned[k] = 32'(lcd_segment_pin_count_q) > (PIN_COUNT - 1 - k);
		end else begin : g_fixed
			assign lcd_owned[k] = 1'b0;
		end
	end
	assign LCD_SEGMENT_MODE_OUT = lcd_owned[PIN_COUNT-1 -: SHARED_PINS];

	// ============================================================
	// Pin drivers with special-function overrides.
	logic [PIN_COUNT-1:0] drive_val, drive_en;
	always_comb begin
		drive_val = out_latch;
		drive_en  = pin_direction_bit & ~lcd_owned;
		if (strobe_pulse_enable && pin_direction_bit[STROBE_PIN]) begin
			drive_val[STROBE_PIN] = CE_STROBE_IN;
		end
		if (fault_pulse_enable && pin_direction_bit[FAULT_PIN]) begin
			drive_val[FAULT_PIN] = CE_FAULT_PULSE_IN;
		end
		if (eeprom_pins_enable) begin
			drive_val[EEPROM_CLK_PIN]  = EE_CLK_IN;
			drive_en[EEPROM_CLK_PIN]   = !lcd_owned[EEPROM_CLK_PIN];
			drive_val[EEPROM_DATA_PIN] = EE_DATA_IN;
			drive_en[EEPROM_DATA_PIN]  = EE_DATA_OE_IN && !lcd_owned[EEPROM_DATA_PIN];
		end
	end
	assign PIN_OUT      = drive_val;
	assign PIN_OE_N_OUT = ~drive_en;
	assign EE_DATA_OUT  = PIN_IN[EEPROM_DATA_PIN];

	// ============================================================
	// Resource routing watches the pin level whether input or output.
	assign general_pin = PIN_IN & ~lcd_owned;

	logic hi_rise, lo_rise, hi_fall, lo_fall;
	dgio_route #(
		.ROUTED_PINS (ROUTED_PINS)
	) u_route (
		.level_in    (general_pin[ROUTED_PINS-1:0]),
		.select_in   (pin_resource_select),
		.timer0_out  (TIMER0_COUNT_INPUT_OUT),
		.timer1_out  (TIMER1_COUNT_INPUT_OUT),
		.hi_rise_out (hi_rise),
		.lo_rise_out (lo_rise),
		.hi_fall_out (hi_fall),
		.lo_fall_out (lo_fall)
	);

	// A falling lane ORs pin highs, so a falling edge is seen on that OR.
	dgio_edge u_high_irq (
		.clk_in   (MCLK_IN),
		.rst_n_in (RESET_N_IN),
		.ce_in    (CLK_EN_IN),
		.rise_in  (hi_rise),
		.fall_in  (hi_fall),
		.ack_in   (HIGH_IRQ_ACK_IN),
		.flag_out (HIGH_PRIORITY_PIN_IRQ_OUT)
	);

	dgio_edge u_low_irq (
		.clk_in   (MCLK_IN),
		.rst_n_in (RESET_N_IN),
		.ce_in    (CLK_EN_IN),
		.rise_in  (lo_rise),
		.fall_in  (lo_fall),
		.ack_in   (LOW_IRQ_ACK_IN),
		.flag_out (LOW_PRIORITY_PIN_IRQ_OUT)
	);
endmodule : dgio_top

/* tb/dgio_chk.sv */
`timescale 1ns/1ps
module dgio_chk #(
	parameter int PIN_COUNT   = 22,
	parameter int SHARED_PINS = 18
) (
	input wire logic                   MCLK_IN,
	input wire logic                   RESET_N_IN,
	input wire logic                   CLK_EN_IN,
	input wire logic [7:0]             SFR_ADDR_IN,
	input wire logic [7:0]             SFR_WDATA_IN,
	input wire logic                   SFR_WR_IN,
	input wire logic                   SFR_RD_IN,
	input wire logic [7:0]             SFR_RDATA_OUT,
	input wire logic [PIN_COUNT-1:0]   PIN_IN,
	input wire logic [PIN_COUNT-1:0]   PIN_OUT,
	input wire logic [PIN_COUNT-1:0]   PIN_OE_N_OUT,
	input wire logic [SHARED_PINS-1:0] LCD_SEGMENT_MODE_OUT,
	input wire logic                   EE_DATA_OUT,
	input wire logic                   HIGH_IRQ_ACK_IN,
	input wire logic                   HIGH_PRIORITY_PIN_IRQ_OUT
);
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	a_reset_inputs: assert property ($rose(RESET_N_IN) |-> &PIN_OE_N_OUT)
		else $error("pin driven after reset");
	a_unmapped_zero: assert property (SFR_RD_IN && CLK_EN_IN && !(SFR_ADDR_IN inside
		{8'h80, 8'h90, 8'h91, 8'hA0, 8'hA1, 8'hA2}) |=> SFR_RDATA_OUT == 8'h00)
		else $error("unmapped read not zero");
	a_lcd_no_drive: assert property ((LCD_SEGMENT_MODE_OUT & ~PIN_OE_N_OUT[21:4]) == '0)
		else $error("segment pin driven");
	a_lcd_from_top: assert property
		(((~LCD_SEGMENT_MODE_OUT) & ((~LCD_SEGMENT_MODE_OUT) + 1'b1)) == '0)
		else $error("segment pins not taken from top");
	a_eeprom_data: assert property (EE_DATA_OUT == PIN_IN[5])
		else $error("eeprom data not pin level");
	a_dir_write: assert property (SFR_WR_IN && CLK_EN_IN && SFR_ADDR_IN == 8'hA2 |=>
		{4'h0, PIN_OE_N_OUT[3:0]} == (~$past(SFR_WDATA_IN) & 8'h0F))
		else $error("direction write not applied");
	a_data_write: assert property (SFR_WR_IN && CLK_EN_IN && SFR_ADDR_IN == 8'h80 |=>
		((({4'h0, PIN_OUT[3:0]} ^ $past(SFR_WDATA_IN)) & {4'h0, ~PIN_OE_N_OUT[3:0]}) == 8'h00))
		else $error("data write not on pins");
	a_flag_sticky: assert property (HIGH_PRIORITY_PIN_IRQ_OUT && !HIGH_IRQ_ACK_IN
		|=> HIGH_PRIORITY_PIN_IRQ_OUT)
		else $error("flag lost without ack");
endmodule : dgio_chk

bind dgio_top dgio_chk #(.PIN_COUNT(PIN_COUNT), .SHARED_PINS(SHARED_PINS)) u_dgio_chk (
	.MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN), .CLK_EN_IN(CLK_EN_IN),
	.SFR_ADDR_IN(SFR_ADDR_IN), .SFR_WDATA_IN(SFR_WDATA_IN), .SFR_WR_IN(SFR_WR_IN),
	.SFR_RD_IN(SFR_RD_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
	.PIN_OE_N_OUT(PIN_OE_N_OUT), .LCD_SEGMENT_MODE_OUT(LCD_SEGMENT_MODE_OUT),
	.EE_DATA_OUT(EE_DATA_OUT), .HIGH_IRQ_ACK_IN(HIGH_IRQ_ACK_IN),
	.HIGH_PRIORITY_PIN_IRQ_OUT(HIGH_PRIORITY_PIN_IRQ_OUT)
);

/* tb/dgio_pins.sv */
`timescale 1ns/1ps
module dgio_pins #(
	parameter int PIN_COUNT = 22
) (
	input  wire logic [PIN_COUNT-1:0] drive_in,
	input  wire logic [PIN_COUNT-1:0] oe_n_in,
	input  wire logic [PIN_COUNT-1:0] ext_in,
	output logic [PIN_COUNT-1:0]      level_out
);
	// A driven pin reads back its own value; an undriven pin shows the outside level.
	assign level_out = (drive_in & ~oe_n_in) | (ext_in & oe_n_in);
endmodule : dgio_pins

/* tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) \
	begin \
		check_count++; \
		if ((a) !== (e)) begin \
			n_mismatch++; \
			$display("unexpected at %0t: got %h want %h", $time, (a), (e)); \
		end \
	end
module testbench;
	logic        mclk, rst_n, s_wr, s_rd, c_wr, c_rd, t0, t1, irq_hi, irq_lo;
	logic        strobe, fault, ee_clk, ee_d, ee_oe, ack_hi, ack_lo, ee_out, ce;
	logic [7:0]  s_addr, s_wd, s_rdata, c_wd, c_rdata, d;
	logic [15:0] c_addr;
	logic [21:0] ext, pin_in, pin_out, oe_n;
	logic [17:0] lcd;
	logic [23:0] e;
	int          n_mismatch = 0, check_count = 0, cyc = 0;
	logic [7:0]  dreg [3] = '{8'h80, 8'h90, 8'hA0};
	logic [7:0]  rdir [3] = '{8'hA2, 8'h91, 8'hA1};
	dgio_top u_dgio_top (
		.MCLK_IN(mclk), .RESET_N_IN(rst_n), .CLK_EN_IN(ce), .SFR_ADDR_IN(s_addr),
		.SFR_WDATA_IN(s_wd), .SFR_WR_IN(s_wr), .SFR_RD_IN(s_rd), .SFR_RDATA_OUT(s_rdata),
		.CFG_ADDR_IN(c_addr), .CFG_WDATA_IN(c_wd), .CFG_WR_IN(c_wr), .CFG_RD_IN(c_rd),
		.CFG_RDATA_OUT(c_rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N_OUT(oe_n),
		.LCD_SEGMENT_MODE_OUT(lcd), .CE_STROBE_IN(strobe), .CE_FAULT_PULSE_IN(fault),
		.EE_CLK_IN(ee_clk), .EE_DATA_IN(ee_d), .EE_DATA_OE_IN(ee_oe), .EE_DATA_OUT(ee_out),
		.TIMER0_COUNT_INPUT_OUT(t0), .TIMER1_COUNT_INPUT_OUT(t1), .HIGH_IRQ_ACK_IN(ack_hi),
		.LOW_IRQ_ACK_IN(ack_lo), .HIGH_PRIORITY_PIN_IRQ_OUT(irq_hi),
		.LOW_PRIORITY_PIN_IRQ_OUT(irq_lo)
	);
	dgio_pins u_dgio_pins (.drive_in(pin_out), .oe_n_in(oe_n), .ext_in(ext), .level_out(pin_in));
	// ============================================================
	// Clock, hang guard and closing report.
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test
	// ============================================================
	// One register access on either port; read data is settled on return.
	task automatic acc(input bit cfg, input bit wr, input logic [15:0] a, input logic [7:0] v);
		s_addr = a[7:0];
		c_addr = a;
		s_wd = v;
		c_wd = v;
		{s_wr, s_rd, c_wr, c_rd} = {!cfg && wr, !cfg && !wr, cfg && wr, cfg && !wr};
		@(negedge mclk);
		{s_wr, s_rd, c_wr, c_rd} = 4'h0;
		@(negedge mclk);
	endtask : acc
	task automatic ack_both();
		repeat (3) @(negedge mclk);
		{ack_hi, ack_lo} = 2'b11;
		@(negedge mclk);
		{ack_hi, ack_lo} = 2'b00;
		@(negedge mclk);
	endtask : ack_both
	// ============================================================
	// Test sequence.
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		{s_wr, s_rd, c_wr, c_rd, strobe, fault, ee_clk, ee_d, ee_oe, ack_hi, ack_lo} = '0;
		{s_addr, s_wd, c_wd, c_addr} = '0;
		ext = 22'h35_A5C3;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		for (int i = 0; i < 3; i++) begin
			e = {2'b00, ext} >> (8 * i);
			d = (i == 2) ? 8'h3F : 8'hFF;
			acc(0, 0, rdir[i], 8'h00);
			`CHK(s_rdata, 8'h00)
			acc(0, 0, dreg[i], 8'h00);
			`CHK(s_rdata, e[7:0])
			acc(0, 1, rdir[i], 8'hFF);
			acc(0, 0, rdir[i], 8'h00);
			`CHK(s_rdata, d)
			acc(0, 1, dreg[i], 8'h5A);
			acc(0, 0, dreg[i], 8'h00);
			`CHK(s_rdata, d & 8'h5A)
		end
		acc(0, 0, 16'h0081, 8'h00);
		`CHK(s_rdata, 8'h00)
		`CHK(oe_n, 22'h00_0000)
		`CHK(pin_out, 22'h1A_5A5A)
		$display("port map test done");
		for (int n = 0; n < 32; n += 6) begin
			acc(1, 1, 16'h2020, 8'(n));
			`CHK(lcd, (n >= 18) ? 18'h3_FFFF : 18'(((1 << n) - 1) << (18 - n)))
		end
		acc(1, 1, 16'h2020, 8'hFF);
		acc(1, 0, 16'h2020, 8'h00);
		`CHK(c_rdata, 8'h1F)
		`CHK(oe_n, 22'h3F_FFF0)
		acc(1, 1, 16'h2020, 8'h00);
		$display("segment pin test done");
		acc(1, 1, 16'h2009, 8'hFF);
		acc(1, 0, 16'h2009, 8'h00);
		`CHK(c_rdata, 8'h77)
		acc(1, 1, 16'h2009, 8'h22);
		for (int v = 0; v < 4; v++) begin
			acc(0, 1, 16'h0080, 8'(v));
			`CHK({t0, t1}, {v != 0, 1'b0})
		end
		acc(1, 1, 16'h2009, 8'h00);
		acc(1, 1, 16'h200E, 8'h30);
		`CHK({t0, t1}, 2'b01)
		acc(0, 1, 16'h0090, 8'h00);
		`CHK(t1, 1'b0)
		acc(1, 1, 16'h200E, 8'h00);
		for (int k = 4; k < 8; k++) begin
			acc(0, 1, 16'h0080, {7'h00, k > 5});
			acc(1, 1, 16'h2009, 8'(k));
			ack_both();
			`CHK({irq_hi, irq_lo}, 2'b00)
			acc(0, 1, 16'h0080, {7'h00, k < 6});
			repeat (3) @(negedge mclk);
			`CHK({irq_hi, irq_lo}, k[0] ? 2'b01 : 2'b10)
		end
		acc(1, 1, 16'h2009, 8'h00);
		ack_both();
		$display("routing test done");
		acc(1, 1, 16'h2008, 8'h1C);
		ee_oe = 1'b1;
		for (int p = 0; p < 2; p++) begin
			{fault, strobe, ee_d, ee_clk} = p ? 4'hA : 4'h5;
			@(negedge mclk);
			`CHK(pin_out[7:4], p ? 4'hA : 4'h5)
			`CHK(oe_n[7:4], 4'h0)
		end
		ee_oe = 1'b0;
		acc(1, 1, 16'h2008, 8'h10);
		`CHK(oe_n[5], 1'b1)
		`CHK(pin_out[7:6], 2'b00)
		`CHK(ee_out, ext[5])
		$display("special function test done");
		// A write with the clock enable low must leave the register untouched.
		ce = 1'b0;
		acc(0, 1, 16'h00A2, 8'h00);
		ce = 1'b1;
		acc(0, 0, 16'h00A2, 8'h00);
		`CHK(s_rdata, 8'hFF)
		$display("clock enable test done");
		end_of_test();
	end
endmodule : testbench
